// File: core/flow_defs.vh
// Constants for the program flow and operand handling core
`ifndef FLOW_DEFS_VH
`define FLOW_DEFS_VH

// Status register field positions
`define STAT_CARRY        0
`define STAT_ZERO         2
`define STAT_SEG_HI       7
`define STAT_SEG_LO       5
`define STAT_RESET        8'h00

// File register addresses
`define FR_INDIRECT       8'h00
`define FR_RTC            8'h01
`define FR_PCL            8'h02
`define FR_STATUS         8'h03
`define FR_FSR            8'h04

// Program counter
`define PC_RESET          11'h7FF
`define STACK_DEPTH       8

// Opcode classes (12-bit words)
`define OP_SEGSEL_HI      9'b0000_0001_0
`define OP_RET            12'h00C
`define OP_EXIT_WITH_SEGMENT_LOAD           12'h00D
`define OP_INTERRUPT_EXIT           12'h00E
`define OP_INTERRUPT_EXIT_ADD_ACC          12'h00F
`define OP_BANK_HI        9'b0000_0001_1

`endif

// File: core/return_stack.v
// Hardware return stack for call and return linkage
`timescale 1ns/1ps

module return_stack #(
  parameter DEPTH = 8,
  parameter WIDTH = 11
) (
  input  wire             ref_clk,
  input  wire             rstn,
  input  wire             push,
  input  wire             pop,
  input  wire [WIDTH-1:0] push_data,
  output wire [WIDTH-1:0] top
);

  reg [WIDTH-1:0] entry [0:DEPTH-1];

  assign top = entry[0];

  // --------------------------------------------------
  // Shift register stack
  // --------------------------------------------------
  // Shift form keeps the top fixed; deepest entry falls off on overflow
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_entry
      always @(posedge ref_clk or negedge rstn)
      begin
        if (!rstn)
          entry[i] <= {WIDTH{1'b0}};
        else if (push)
          entry[i] <= (i == 0) ? push_data : entry[(i == 0) ? 0 : i - 1];
        else if (pop)
          entry[i] <= (i == DEPTH - 1) ? entry[i] : entry[(i == DEPTH - 1) ? i : i + 1];
      end
    end
  endgenerate

endmodule // return_stack

// File: core/program_flow_control.v
// Program flow, skip and logic execution core
`timescale 1ns/1ps
`include "flow_defs.vh"

// What this block does
// RQ1: A call pushes the incremented program counter onto the stack.
// RQ2: A call loads the counter low byte from the instruction address bits.
// RQ3: A call forces program counter bit 8 to zero.
// RQ4: A call takes the two top counter bits from segment bits.
// RQ5: Call targets therefore land in the lower half of a segment.
// RQ6: A jump takes its destination segment from the segment bits.
// RQ7: A call uses whatever segment value is held at that moment.
// RQ8: The segment select instruction loads the segment bits in one cycle.
// RQ9: The segment select operand is limited to values 0 to 3.
// RQ10: Plain subroutine exit restores the counter and keeps the accumulator.
// RQ11: Segment loading exit also sets the low segment bits from address.
// RQ12: A distinct interrupt exit resumes the interrupted program.
// RQ13: Interrupt exit with accumulator adds it to the realtime counter.
// RQ14: Literal exit returns and loads the literal into the accumulator.
// RQ15: A true skip condition suppresses the following instruction, and the next one too if that is a segment or bank select.
// RQ16: Skips on decrement zero, increment zero, bit clear, bit set.
// RQ17: A skip over a segment or bank select skips two, three cycles.
// RQ18: AND, OR, XOR combine accumulator and memory, direct or indirect.
// RQ19: Rotates move a file register through carry, left or right.
// RQ20: One's complement of a file register and of the accumulator.
// RQ21: Nibble swap of a file register result goes to accumulator.
// RQ22: Segment bits sit in status bits 7 to 5, 200h words each.
// RQ23: Skip takes one cycle without skip, two with skip.
// RQ24: Every exit pops the top stack entry into the program counter.
module program_flow_control #(
  parameter STACK_DEPTH = `STACK_DEPTH
) (
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire [11:0] instr,
  input  wire        instr_valid,
  input  wire [7:0]  fr_rdata,
  output reg  [10:0] pc,
  output reg  [7:0]  fr_addr,
  output reg  [7:0]  fr_wdata,
  output reg         fr_we,
  output reg  [7:0]  acc,
  output reg  [7:0]  status,
  output reg  [7:0]  realtime_counter,
  output reg  [7:0]  fsr,
  output reg         skipping
);

  // --------------------------------------------------
  // Decode helpers
  // --------------------------------------------------
  wire [4:0] f_field  = instr[4:0];
  wire [2:0] bit_sel  = instr[7:5];
  wire       to_fr    = instr[5];
  // Indirect access goes through the file select register
  wire [7:0] ea       = (f_field == 5'h00) ? fsr : {3'b000, f_field};
  wire       carry    = status[`STAT_CARRY];
  wire [10:0] pc_inc  = pc + 11'h001;
  wire [10:0] stack_top;
  wire       is_segsel = (instr[11:3] == `OP_SEGSEL_HI);
  wire       is_bank   = (instr[11:3] == `OP_BANK_HI);

  // Effective operand, with the core-held registers shadowing memory
  reg  [7:0] opnd;
  always @*
  begin
    case (ea)
      `FR_RTC:    opnd = realtime_counter;
      `FR_PCL:    opnd = pc[7:0];
      `FR_STATUS: opnd = status;
      `FR_FSR:    opnd = fsr;
      default:    opnd = fr_rdata;
    endcase
  end

  // --------------------------------------------------
  // Execute stage: next values
  // --------------------------------------------------
  reg [10:0] next_pc;
  reg [7:0]  next_acc;
  reg [7:0]  next_status;
  reg [7:0]  next_rtc;
  reg [7:0]  next_fsr;
  reg [7:0]  next_wdata;
  reg        next_we;
  reg        next_skip;
  reg        push;
  reg        pop;
  reg [7:0]  res;
  reg        cond;
  reg        wr_res;

  always @*
  begin
    next_pc     = pc_inc;
    next_acc    = acc;
    next_status = status;
    next_rtc    = realtime_counter;
    next_fsr    = fsr;
    next_wdata  = 8'h00;
    next_we     = 1'b0;
    next_skip   = 1'b0;
    push        = 1'b0;
    pop         = 1'b0;
    res         = 8'h00;
    cond        = 1'b0;
    wr_res      = 1'b0;
    if (!instr_valid)
      next_pc = pc;
    else if (skipping)
    begin
      // RQ17 skip over select
      // A skipped segment or bank select extends the skip by one word
      next_skip = is_segsel || is_bank;
    end
    else
    begin
      case (instr[11:8])
        4'h0:
        begin
          if (instr == `OP_RET)
          begin
            // RQ10 plain exit
            // RQ24 pop to counter
            next_pc = stack_top;
            pop     = 1'b1;
          end
          else if (instr == `OP_EXIT_WITH_SEGMENT_LOAD)
          begin
            // RQ11 segment from address
            next_pc = stack_top;
            pop     = 1'b1;
            next_status[`STAT_SEG_LO+1:`STAT_SEG_LO] = stack_top[10:9];
          end
          else if (instr == `OP_INTERRUPT_EXIT)
          begin
            // RQ12 interrupt exit
            next_pc = stack_top;
            pop     = 1'b1;
          end
          else if (instr == `OP_INTERRUPT_EXIT_ADD_ACC)
          begin
            // RQ13 add to realtime counter
            next_pc  = stack_top;
            pop      = 1'b1;
            next_rtc = realtime_counter + acc;
          end
          else if (is_segsel)
          begin
            // RQ8 one cycle select
            // RQ9 operand 0 to 3
            // RQ22 top bit stays clear
            next_status[`STAT_SEG_HI:`STAT_SEG_LO] = {1'b0, instr[1:0]};
          end
          else if (instr[7:6] == 2'b00 && instr[5])
          begin
            // Move accumulator to file register
            res    = acc;
            wr_res = 1'b1;
          end
        end
        4'h1:
        begin
          // RQ18 logical operations, plus add
          case (instr[7:6])
            2'b00:   res = acc | opnd;
            2'b01:   res = acc & opnd;
            2'b10:   res = acc ^ opnd;
            default: res = acc + opnd;
          endcase
          next_status[`STAT_ZERO] = (res == 8'h00);
          wr_res = 1'b1;
        end
        4'h2:
        begin
          case (instr[7:6])
            2'b00:   res = opnd;
            // RQ20 file complement
            2'b01:   res = ~opnd;
            2'b10:   res = opnd + 8'h01;
            default: res = opnd - 8'h01;
          endcase
          if (instr[7:6] == 2'b11)
          begin
            // RQ16 decrement skip zero
            // RQ15 skip on true
            next_skip = (res == 8'h00);
          end
          else
            next_status[`STAT_ZERO] = (res == 8'h00);
          wr_res = 1'b1;
        end
        4'h3:
        begin
          case (instr[7:6])
            // RQ19 rotate right through carry
            2'b00:
            begin
              res = {carry, opnd[7:1]};
              next_status[`STAT_CARRY] = opnd[0];
            end
            // RQ19 rotate left through carry
            2'b01:
            begin
              res = {opnd[6:0], carry};
              next_status[`STAT_CARRY] = opnd[7];
            end
            // RQ21 nibble swap
            2'b10:   res = {opnd[3:0], opnd[7:4]};
            // RQ16 increment skip zero
            default:
            begin
              res       = opnd + 8'h01;
              next_skip = (res == 8'h00);
            end
          endcase
          wr_res = 1'b1;
        end
        4'h4, 4'h5:
        begin
          // Bit clear or set
          res    = instr[8] ? (opnd | (8'h01 << bit_sel))
                            : (opnd & ~(8'h01 << bit_sel));
          next_we    = 1'b1;
          next_wdata = res;
        end
        4'h6, 4'h7:
        begin
          // RQ16 bit test skips
          // RQ23 one or two cycles
          cond      = opnd[bit_sel];
          next_skip = instr[8] ? cond : !cond;
        end
        4'h8:
        begin
          // RQ14 literal exit
          next_pc  = stack_top;
          pop      = 1'b1;
          next_acc = instr[7:0];
        end
        4'h9:
        begin
          // RQ1 push incremented counter
          // RQ2 low byte from target
          // RQ3 bit 8 forced clear
          // RQ4 top bits from segment
          // RQ5 lower half of segment
          // RQ7 segment as held now
          push    = 1'b1;
          next_pc = {status[`STAT_SEG_LO+1:`STAT_SEG_LO], 1'b0, instr[7:0]};
        end
        4'hA, 4'hB:
        begin
          // RQ6 jump segment from bits
          next_pc = {status[`STAT_SEG_LO+1:`STAT_SEG_LO], instr[8:0]};
        end
        4'hC:    next_acc = instr[7:0];
        4'hD:
        begin
          next_acc = acc | instr[7:0];
          next_status[`STAT_ZERO] = (next_acc == 8'h00);
        end
        4'hE:
        begin
          next_acc = acc & instr[7:0];
          next_status[`STAT_ZERO] = (next_acc == 8'h00);
        end
        default:
        begin
          next_acc = acc ^ instr[7:0];
          next_status[`STAT_ZERO] = (next_acc == 8'h00);
        end
      endcase
      // Result routing: destination bit picks file register or accumulator; increment and decrement skips always write the file register
      if (wr_res)
      begin
        if (to_fr || instr[11:8] == 4'h2 && instr[7:6] == 2'b11 ||
            instr[11:8] == 4'h3 && instr[7:6] == 2'b11 || instr[11:8] == 4'h0)
        begin
          next_we    = 1'b1;
          next_wdata = res;
        end
        else
          next_acc = res;
      end
      // RQ20 accumulator complement via XOR with all ones literal
      // Writes to core-held registers land in the core copy
      if (next_we)
      begin
        case (ea)
          `FR_RTC:    next_rtc    = next_wdata;
          `FR_STATUS: next_status = next_wdata;
          `FR_FSR:    next_fsr    = next_wdata;
          `FR_PCL:    next_pc     = {pc[10:8], next_wdata};
          default:    next_rtc    = next_rtc;
        endcase
      end
    end
  end

  // --------------------------------------------------
  // Return stack
  // --------------------------------------------------
  return_stack #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (11)
  ) u_stack (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .push      (push),
    .pop       (pop),
    .push_data (pc_inc),
    .top       (stack_top)
  );

  // --------------------------------------------------
  // State registers
  // --------------------------------------------------
  // Counter starts at the top word, as after any reset
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pc               <= `PC_RESET;
      acc              <= 8'h00;
      status           <= `STAT_RESET;
      realtime_counter <= 8'h00;
      fsr              <= 8'h00;
      skipping         <= 1'b0;
      fr_addr          <= 8'h00;
      fr_wdata         <= 8'h00;
      fr_we            <= 1'b0;
    end
    else
    begin
      pc               <= next_pc;
      acc              <= next_acc;
      status           <= next_status;
      realtime_counter <= next_rtc;
      fsr              <= next_fsr;
      fr_addr          <= ea;
      fr_wdata         <= next_wdata;
      fr_we            <= next_we && (ea > `FR_FSR);
      if (instr_valid)
        skipping <= next_skip;
    end
  end

endmodule // program_flow_control

// File: sim/program_flow_control_sva.sv
// Assertion checker for the program flow core ports
`timescale 1ns/1ps

module program_flow_control_sva (
  input wire        ref_clk,
  input wire        rstn,
  input wire [11:0] instr,
  input wire        instr_valid,
  input wire [7:0]  fr_rdata,
  input wire [10:0] pc,
  input wire [7:0]  acc,
  input wire [7:0]  status,
  input wire [7:0]  realtime_counter,
  input wire        skipping
);
  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Only words that really execute count, a suppressed word changes nothing
  wire run     = instr_valid && !skipping;
  wire tst_bit = fr_rdata[instr[7:5]];
  wire is_call = run && (instr[11:8] == 4'h9);
  wire is_jump = run && (instr[11:9] == 3'b101);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_call_low_byte: assert property (is_call |=> pc[7:0] == $past(instr[7:0]))
    else $error("call low byte wrong");
  a_call_bit_eight: assert property (is_call |=> !pc[8])
    else $error("call bit eight not cleared");
  a_call_segment: assert property (is_call |=> pc[10:9] == $past(status[6:5]))
    else $error("call segment bits wrong");
  a_jump_target: assert property (is_jump |=> pc == {$past(status[6:5]), $past(instr[8:0])})
    else $error("jump target wrong");
  a_segsel_load: assert property (run && instr[11:2] == 10'h004 |=>
    status[7:5] == {1'b0, $past(instr[1:0])})
    else $error("segment select not loaded");
  a_literal_exit: assert property (run && instr[11:8] == 4'h8 |=> acc == $past(instr[7:0]))
    else $error("literal exit acc wrong");
  a_exit_keeps_acc: assert property (run && instr == 12'h00c |=> $stable(acc))
    else $error("plain exit changed acc");
  a_skip_no_effect: assert property (instr_valid && skipping |=>
    pc == $past(pc) + 11'd1 && $stable(acc))
    else $error("suppressed word had effect");
  a_swap_to_acc: assert property (run && instr[11:5] == 7'b0011100 |=>
    acc == {$past(fr_rdata[3:0]), $past(fr_rdata[7:4])})
    else $error("nibble swap wrong");
  a_skip_clear_bit: assert property (run && instr[11:8] == 4'h6 |=>
    skipping == !$past(tst_bit))
    else $error("bit clear skip wrong");
  a_skip_extends: assert property (instr_valid && skipping && instr[11:4] == 8'h01 |=>
    skipping)
    else $error("extended skip not kept");

  // Main scenarios reached
  c_call: cover property (is_call);
  c_ext_skip: cover property (instr_valid && skipping && instr[11:4] == 8'h01);
  c_exit_add: cover property (run && instr == 12'h00f);
endmodule // program_flow_control_sva

// File: sim/program_flow_control_tb.sv
// Self-checking bench for the program flow core
`timescale 1ns/1ps

module program_flow_control_tb;
  reg         ref_clk;
  reg         rstn;
  reg  [11:0] instr;
  reg         instr_valid;
  reg  [7:0]  fr_rdata;
  wire [10:0] pc;
  wire [7:0]  fr_addr;
  wire [7:0]  fr_wdata;
  wire        fr_we;
  wire [7:0]  acc;
  wire [7:0]  status;
  wire [7:0]  realtime_counter;
  wire [7:0]  fsr;
  wire        skipping;
  integer     n_fail;
  integer     compares;
  integer     seed;
  integer     i;
  integer     j;
  reg  [10:0] ep;
  reg  [10:0] ret;
  reg  [7:0]  ea;
  reg  [7:0]  v;
  reg  [7:0]  k;
  reg  [11:0] op;
  reg         ec;
  reg         cond;

  program_flow_control dut (
    .ref_clk          (ref_clk),
    .rstn             (rstn),
    .instr            (instr),
    .instr_valid      (instr_valid),
    .fr_rdata         (fr_rdata),
    .pc               (pc),
    .fr_addr          (fr_addr),
    .fr_wdata         (fr_wdata),
    .fr_we            (fr_we),
    .acc              (acc),
    .status           (status),
    .realtime_counter (realtime_counter),
    .fsr              (fsr),
    .skipping         (skipping)
  );

  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  // ----------------------------------------
  // Tasks and model functions
  // ----------------------------------------
  task chk(input [10:0] seen, input [10:0] want);
    begin
      compares = compares + 1;
      if (seen !== want)
      begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
      end
    end
  endtask

  // One word, then an idle edge so the same word is never taken twice
  task exec(input [11:0] w, input [7:0] rd);
    begin
      @(posedge ref_clk);
      instr       <= w;
      fr_rdata    <= rd;
      instr_valid <= 1'b1;
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      fr_rdata    <= ~rd;
      @(negedge ref_clk);
      ep = ep + 11'd1;
    end
  endtask

  task give_verdict;
    begin
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // Upper opcode field of each accumulator-target operation
  function [6:0] lop(input [2:0] s);
    case (s)
      3'd0: lop = 7'b0001010;
      3'd1: lop = 7'b0001000;
      3'd2: lop = 7'b0001100;
      3'd3: lop = 7'b0010010;
      3'd4: lop = 7'b0011100;
      3'd5: lop = 7'b0011010;
      default: lop = 7'b0011000;
    endcase
  endfunction

  // Returns carry and accumulator after the operation
  function [8:0] lres(input [2:0] s, input [7:0] a, input [7:0] d, input c);
    case (s)
      3'd0: lres = {c, a & d};
      3'd1: lres = {c, a | d};
      3'd2: lres = {c, a ^ d};
      3'd3: lres = {c, ~d};
      3'd4: lres = {c, d[3:0], d[7:4]};
      3'd5: lres = {d, c};
      default: lres = {d[0], c, d[7:1]};
    endcase
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    seed = 35; n_fail = 0; compares = 0; ref_clk = 1'b0; rstn = 1'b0;
    instr = 12'h000; instr_valid = 1'b0; fr_rdata = 8'h00;
    ep = 11'h7ff; ea = 8'h00; ec = 1'b0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    chk(pc, ep); chk(acc, ea); chk(status, 8'h00); chk(skipping, 1'b0);
    // Every segment: select, call, plain exit, jump
    for (i = 0; i < 4; i = i + 1)
    begin
      exec({10'h004, i[1:0]}, 8'h00);
      chk(status[7:5], i[2:0]);
      k = $random(seed);
      ret = ep + 11'd1;
      exec({4'h9, k}, 8'h00);
      ep = {i[1:0], 1'b0, k};
      chk(pc, ep);
      exec(12'h00c, 8'h00);
      ep = ret;
      chk(pc, ep);
      chk(acc, ea);
      v = $random(seed);
      exec({3'b101, i[0], v}, 8'h00);
      ep = {i[1:0], i[0], v};
      chk(pc, ep);
    end
    k = $random(seed);
    exec({4'hc, k}, 8'h00);
    ea = k;
    // Segment loading, both interrupt and literal exits after a call in segment 2, segment 1 selected meanwhile
    for (i = 0; i < 4; i = i + 1)
    begin
      exec(12'h012, 8'h00);
      ret = ep + 11'd1;
      exec({4'h9, 6'h25, i[1:0]}, 8'h00);
      ep = {2'b10, 1'b0, 6'h25, i[1:0]};
      chk(pc, ep);
      exec(12'h011, 8'h00);
      k = $random(seed);
      op = (i == 3) ? {4'h8, k} : {10'h003, i[1:0] + 2'b01};
      exec(op, 8'h00);
      ep = ret;
      chk(pc, ep);
      if (i == 0) chk(status[6:5], ret[10:9]);
      if (i == 2) chk(realtime_counter, ea);
      if (i == 3) ea = k;
      chk(acc, ea);
    end
    // Random logic, complement, swap and rotate, direct and indirect
    for (i = 0; i < 40; i = i + 1)
    begin
      j = {$random(seed)} % 7;
      v = $random(seed);
      exec({lop(j[2:0]), i[0], 4'h0}, v);
      {ec, ea} = lres(j[2:0], ea, v, ec);
      chk(acc, ea);
      if (j < 4) chk(status[2], ea == 8'h00);
      else chk(status[0], ec);
    end
    // Complement written back to a file register
    v = $random(seed);
    exec(12'h270, v);
    k = ~v;
    chk(fr_we, 1'b1);
    chk(fr_addr, 8'h10);
    chk(fr_wdata, k);
    // Four skip kinds, condition false then true
    exec(12'h010, 8'h00);
    for (i = 0; i < 8; i = i + 1)
    begin
      cond = i[0];
      k = $random(seed);
      v = $random(seed);
      case (i[2:1])
        2'd0: begin v = cond ? 8'h01 : 8'h80; op = 12'h2f0; end
        2'd1: begin v = cond ? 8'hff : 8'h7f; op = 12'h3f0; end
        2'd2: begin v[k[7:5]] = ~cond; op = {4'h6, k[7:5], 5'h10}; end
        default: begin v[k[7:5]] = cond; op = {4'h7, k[7:5], 5'h10}; end
      endcase
      exec(op, v);
      chk(skipping, cond);
      if (i > 5)
      begin
        exec(12'h013, 8'h00);
        chk(status[6:5], cond ? 2'b00 : 2'b11);
        chk(skipping, cond);
      end
      k = $random(seed);
      exec({4'hc, k}, 8'h00);
      if (!cond) ea = k;
      chk(acc, ea);
      chk(pc, ep);
      if (i > 5 && !cond) exec(12'h010, 8'h00);
    end
    // Indirect operand: file select loaded from the accumulator, then used
    exec(12'hc20, 8'h00);
    exec(12'h024, 8'h00);
    chk(fsr, 8'h20);
    v = $random(seed);
    exec(12'h140, v);
    chk(fr_addr, 8'h20);
    chk(acc, 8'h20 & v);
    give_verdict;
  end
endmodule // program_flow_control_tb

bind program_flow_control program_flow_control_sva u_sva (
  .ref_clk          (ref_clk),
  .rstn             (rstn),
  .instr            (instr),
  .instr_valid      (instr_valid),
  .fr_rdata         (fr_rdata),
  .pc               (pc),
  .acc              (acc),
  .status           (status),
  .realtime_counter (realtime_counter),
  .skipping         (skipping)
);
